//--- bcc_defs.vh
// Summary of operation
// - charge mode and blocking high-impedance mode
// - select level picks 500 mA or unlimited
// - precharge below short, then slew-limited CC
// - float voltage gives CV, termination ends cycle
// - recharge drop, POR or inhibit restarts cycle
// - apply load, validate input for 30 ms
// - every start or restart revalidates input
// - ramp current, hold at special charger floor
// - fold back at 120 C, suspend above shutdown
// - sleep on low headroom, block reverse current
// - input below minimum ends charge, pulses status
// - input overvoltage opens switch until OVP clear, then revalidates
// - battery pin above 4.8 V is fault
// - detection sink 30 ms, 2 V decides battery
// - no-battery mode regulates, exits on restart
// - thermistor hot or cold stops charging
// - status open idle, low charging, 2 Hz fault
// - seven fault kinds drive the status pulse
// - low-side switch off on negative overcurrent
`ifndef BCC_DEFS_VH
`define BCC_DEFS_VH
`define BCC_CLK_KHZ       10000
`define BCC_VALID_MS      30
`define BCC_DETECT_MS     30
`define BCC_BLINK_HALF_MS 250
`define BCC_RAMP_US       100
`define BCC_VALID_CYC     (`BCC_VALID_MS * `BCC_CLK_KHZ)
`define BCC_DETECT_CYC    (`BCC_DETECT_MS * `BCC_CLK_KHZ)
`define BCC_BLINK_CYC     (`BCC_BLINK_HALF_MS * `BCC_CLK_KHZ)
`define BCC_RAMP_CYC      ((`BCC_RAMP_US * `BCC_CLK_KHZ) / 1000)
`define BCC_OFF_CONFIG    4'h0
`define BCC_OFF_STATUS    4'h4
`define BCC_OFF_LEVEL     4'h8
`define BCC_CFG_TARGET_LSB 0
`define BCC_CFG_HIZ_BIT    8
`define BCC_CFG_RESET     9'h0_0ff
`define BCC_ST_STATE_LSB  0
`define BCC_ST_FAULT_LSB  9
`define BCC_RESP_OKAY     2'h0
`define BCC_RESP_SLVERR   2'h2
`endif

//--- bcc_charger.v
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defs.vh"
module bcc_charger #(
  parameter VALID_CYC  = `BCC_VALID_CYC,
  parameter DETECT_CYC = `BCC_DETECT_CYC,
  parameter BLINK_CYC  = `BCC_BLINK_CYC,
  parameter RAMP_CYC   = `BCC_RAMP_CYC,
  parameter CNT_W      = 24,
  parameter LEVEL_W    = 8
) (
  input  wire               clock,
  input  wire               rst_b,
  input  wire               awvalid,
  output reg                awready,
  input  wire [3:0]         awaddr,
  input  wire               wvalid,
  output reg                wready,
  input  wire [31:0]        wdata,
  input  wire [3:0]         wstrb,
  output reg                bvalid,
  input  wire               bready,
  output reg  [1:0]         bresp,
  input  wire               arvalid,
  output reg                arready,
  input  wire [3:0]         araddr,
  output reg                rvalid,
  input  wire               rready,
  output reg  [31:0]        rdata,
  output reg  [1:0]         rresp,
  input  wire               inhibit,
  input  wire               input_limit_sel,
  input  wire               vbus_above_min,
  input  wire               vbus_ovp_trip,
  input  wire               vbus_ovp_clear,
  input  wire               vbus_below_sleep,
  input  wire               vbus_at_sp_floor,
  input  wire               vbat_above_short,
  input  wire               vbat_at_float,
  input  wire               vbat_below_recharge,
  input  wire               vbat_above_2v,
  input  wire               vbat_over_4v8,
  input  wire               ichg_at_term,
  input  wire               ramp_at_limit,
  input  wire               die_at_foldback,
  input  wire               die_over_shutdown,
  input  wire               ntc_hot,
  input  wire               ntc_cold,
  input  wire               low_side_neg_over,
  output reg                input_switch_on,
  output reg                input_load_en,
  output reg                reverse_block_en,
  output reg                precharge_en,
  output reg                high_side_en,
  output reg                low_side_en,
  output reg                cv_en,
  output reg                foldback_en,
  output reg                detect_sink_en,
  output reg                nobat_regulate_en,
  output reg                input_limit_500_en,
  output reg  [LEVEL_W-1:0] charge_level,
  output reg                stat_out,
  output reg                stat_oe
);

  // one-hot sequencer states
  localparam [8:0] S_HIZ      = 9'h0_001;
  localparam [8:0] S_VALIDATE = 9'h0_002;
  localparam [8:0] S_PRECHG   = 9'h0_004;
  localparam [8:0] S_CC       = 9'h0_008;
  localparam [8:0] S_CV       = 9'h0_010;
  localparam [8:0] S_DETECT   = 9'h0_020;
  localparam [8:0] S_DONE     = 9'h0_040;
  localparam [8:0] S_NOBAT    = 9'h0_080;
  localparam [8:0] S_SUSPEND  = 9'h0_100;
  // sleep sits above the nine visible state bits
  localparam [9:0] S_SLEEP    = 10'h0_200;

  ////////////////////////////////////////////////////////////////////////////
  // reset release
  // async assert, release through two flops
  reg rst_meta_b;
  reg rst_sync_b;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  function [1:0] reg_sel;
    input [3:0] addr;
    begin
      case (addr)
        `BCC_OFF_CONFIG: reg_sel = 2'd1;
        `BCC_OFF_STATUS: reg_sel = 2'd2;
        `BCC_OFF_LEVEL:  reg_sel = 2'd3;
        default:         reg_sel = 2'd0;
      endcase
    end
  endfunction

  // states in which the buck switches
  function buck_state;
    input [9:0] st;
    begin
      buck_state = st[3] | st[4] | st[7];
    end
  endfunction

  reg  [9:0]         state;
  reg  [9:0]         next_state;
  reg  [8:0]         config_reg;
  reg  [6:0]         faults;
  reg                ovp_flag;
  reg                tsd_flag;
  reg                poor_flag;
  reg                inhibit_d;
  reg  [CNT_W-1:0]   valid_cnt;
  reg  [CNT_W-1:0]   detect_cnt;
  reg  [CNT_W-1:0]   blink_cnt;
  reg  [CNT_W-1:0]   ramp_cnt;
  wire               restart;
  wire               vbus_ok;
  wire               valid_done;
  wire               detect_done;
  wire               charging;
  wire               active;
  wire               suspend_cause;
  wire               fault_any;
  wire [LEVEL_W-1:0] target;

  assign restart     = inhibit_d & ~inhibit;
  assign vbus_ok     = vbus_above_min & ~ovp_flag & ~vbus_ovp_trip;
  assign valid_done  = state[1] & vbus_ok
                       & (valid_cnt == VALID_CYC - 1);
  assign detect_done = state[5] & (detect_cnt == DETECT_CYC - 1);
  assign charging    = |(state[4:2]) | state[7];
  assign active      = ~state[0];
  assign suspend_cause = ovp_flag | tsd_flag | ntc_hot | ntc_cold;
  assign fault_any   = |faults;
  assign target      = config_reg[`BCC_CFG_TARGET_LSB +: LEVEL_W];

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always @* begin
    next_state = state;
    case (state)
      {1'b0, S_HIZ}:
        if (vbus_above_min) next_state = {1'b0, S_VALIDATE};
      {1'b0, S_VALIDATE}:
        if (valid_done) begin
          if (vbat_above_short) next_state = {1'b0, S_CC};
          else next_state = {1'b0, S_PRECHG};
        end
      {1'b0, S_PRECHG}:
        if (vbat_above_short) next_state = {1'b0, S_CC};
      {1'b0, S_CC}:
        if (vbat_at_float) next_state = {1'b0, S_CV};
      {1'b0, S_CV}:
        if (ichg_at_term) next_state = {1'b0, S_DETECT};
      {1'b0, S_DETECT}:
        if (detect_done) begin
          if (vbat_above_2v) next_state = {1'b0, S_DONE};
          else next_state = {1'b0, S_NOBAT};
        end
      {1'b0, S_DONE}:
        if (vbat_below_recharge) next_state = {1'b0, S_VALIDATE};
      {1'b0, S_NOBAT}:
        next_state = state;
      {1'b0, S_SUSPEND}:
        if (!suspend_cause) next_state = {1'b0, S_VALIDATE};
      S_SLEEP:
        if (!vbus_below_sleep) next_state = {1'b0, S_VALIDATE};
      default:
        next_state = {1'b0, S_HIZ};
    endcase
    // overrides in active states, supply loss first
    if (active) begin
      if (!vbus_above_min)
        next_state = {1'b0, S_HIZ};
      else if (suspend_cause)
        next_state = {1'b0, S_SUSPEND};
      else if (vbus_below_sleep)
        next_state = S_SLEEP;
      else if (restart)
        next_state = {1'b0, S_VALIDATE};
    end
    // inhibit and forced high-z beat everything
    if (inhibit || config_reg[`BCC_CFG_HIZ_BIT])
      next_state = {1'b0, S_HIZ};
  end

  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state      <= {1'b0, S_HIZ};
      inhibit_d  <= 1'b0;
      valid_cnt  <= {CNT_W{1'b0}};
      detect_cnt <= {CNT_W{1'b0}};
    end else begin
      state     <= next_state;
      inhibit_d <= inhibit;
      // any dropout restarts the count
      if (state[1] && vbus_ok && !valid_done)
        valid_cnt <= valid_cnt + 1'b1;
      else
        valid_cnt <= {CNT_W{1'b0}};
      if (state[5] && !detect_done)
        detect_cnt <= detect_cnt + 1'b1;
      else
        detect_cnt <= {CNT_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault flags, set wins over clear
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ovp_flag  <= 1'b0;
      tsd_flag  <= 1'b0;
      poor_flag <= 1'b0;
      faults    <= 7'h00;
    end else begin
      if (vbus_ovp_trip) ovp_flag <= 1'b1;
      else if (vbus_ovp_clear) ovp_flag <= 1'b0;
      if (die_over_shutdown) tsd_flag <= 1'b1;
      else if (!die_at_foldback) tsd_flag <= 1'b0;
      // poor input kept until a fresh validation, inhibit or forced high-z
      if (charging && !vbus_above_min) poor_flag <= 1'b1;
      else if (valid_done || inhibit || config_reg[`BCC_CFG_HIZ_BIT])
        poor_flag <= 1'b0;
      faults <= {ntc_hot | ntc_cold, state[7], tsd_flag, vbat_over_4v8,
                 poor_flag, state[9], ovp_flag};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current ramp
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ramp_cnt     <= {CNT_W{1'b0}};
      charge_level <= {LEVEL_W{1'b0}};
    end else if (!(state[3] || state[4])) begin
      ramp_cnt     <= {CNT_W{1'b0}};
      charge_level <= {LEVEL_W{1'b0}};
    // one step per ramp period, clipped back to target at period end
    end else if (ramp_cnt == RAMP_CYC - 1) begin
      ramp_cnt <= {CNT_W{1'b0}};
      if (charge_level > target)
        charge_level <= target;
      else if (!vbus_at_sp_floor && !ramp_at_limit
               && charge_level < target)
        charge_level <= charge_level + 1'b1;
    end else begin
      ramp_cnt <= ramp_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power stage controls and status pin
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      input_switch_on    <= 1'b0;
      input_load_en      <= 1'b0;
      reverse_block_en   <= 1'b1;
      precharge_en       <= 1'b0;
      high_side_en       <= 1'b0;
      low_side_en        <= 1'b0;
      cv_en              <= 1'b0;
      foldback_en        <= 1'b0;
      detect_sink_en     <= 1'b0;
      nobat_regulate_en  <= 1'b0;
      input_limit_500_en <= 1'b1;
      stat_out           <= 1'b0;
      stat_oe            <= 1'b0;
      blink_cnt          <= {CNT_W{1'b0}};
    end else begin
      input_switch_on    <= active & ~ovp_flag & ~vbus_ovp_trip;
      input_load_en      <= state[1] & vbus_above_min;
      reverse_block_en   <= state[0] | state[9];
      precharge_en       <= state[2];
      high_side_en       <= buck_state(state);
      low_side_en        <= buck_state(state) & ~low_side_neg_over;
      cv_en              <= state[4] | state[7];
      foldback_en        <= charging & die_at_foldback;
      detect_sink_en     <= state[5];
      nobat_regulate_en  <= state[7];
      input_limit_500_en <= ~input_limit_sel;
      stat_out           <= 1'b0;
      // pin sinks while charging, blinks on any fault
      if (fault_any) begin
        if (blink_cnt == BLINK_CYC - 1) begin
          blink_cnt <= {CNT_W{1'b0}};
          stat_oe   <= ~stat_oe;
        end else begin
          blink_cnt <= blink_cnt + 1'b1;
        end
      end else begin
        blink_cnt <= {CNT_W{1'b0}};
        stat_oe   <= charging | state[5];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register bus slave
  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      awready    <= 1'b0;
      wready     <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `BCC_RESP_OKAY;
      config_reg <= `BCC_CFG_RESET;
    end else begin
      // address and data taken together
      if (awready && awvalid && wvalid) begin
        awready <= 1'b0;
        wready  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= (reg_sel(awaddr) == 2'd0) ? `BCC_RESP_SLVERR
                                              : `BCC_RESP_OKAY;
        if (reg_sel(awaddr) == 2'd1) begin
          if (wstrb[0])
            config_reg[7:0] <= wdata[7:0];
          if (wstrb[1])
            config_reg[8] <= wdata[`BCC_CFG_HIZ_BIT];
        end
      end else if (awvalid && wvalid && !bvalid) begin
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `BCC_RESP_OKAY;
    end else begin
      // one read in flight at a time
      if (arready && arvalid) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `BCC_RESP_OKAY;
        case (reg_sel(araddr))
          2'd1: rdata <= {23'h00_0000, config_reg};
          // sleep shows only as a fault bit
          2'd2: rdata <= {16'h0000, faults, state[8:0]};
          2'd3: rdata <= {{(32-LEVEL_W){1'b0}}, charge_level};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `BCC_RESP_SLVERR;
          end
        endcase
      end else if (arvalid && !rvalid) begin
        arready <= 1'b1;
      end
      if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end

endmodule // bcc_charger
`default_nettype wire

//--- bcc_unused_placeholder_removed.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- bcc_charger_props.sv
`timescale 1ns/1ps
`default_nettype none
module bcc_charger_props #(
  parameter int VALID_CYC = 20
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic inhibit,
  input wire logic input_limit_sel,
  input wire logic vbus_above_min,
  input wire logic vbus_ovp_trip,
  input wire logic ntc_hot,
  input wire logic low_side_neg_over,
  input wire logic input_switch_on,
  input wire logic precharge_en,
  input wire logic high_side_en,
  input wire logic low_side_en,
  input wire logic input_limit_500_en,
  input wire logic stat_out,
  input wire logic stat_oe
);
  int valid_run;
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // cycles of clean supply in a row
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      valid_run <= 0;
    end else if (vbus_above_min && !vbus_ovp_trip) begin
      valid_run <= (valid_run > VALID_CYC) ? valid_run : valid_run + 1;
    end else begin
      valid_run <= 0;
    end
  end
  ////////////////////////////////////////
  sequence s_off;
    !high_side_en && !low_side_en && !precharge_en;
  endsequence
  sequence s_blink_run;
    ntc_hot[*8];
  endsequence
  a_inhibit_off: assert property (inhibit[*4] |-> s_off)
    else $error("charger active while inhibited");
  a_limit_on: assert property (!input_limit_sel[*5] |-> input_limit_500_en)
    else $error("input limit missing");
  a_limit_off: assert property (input_limit_sel[*5] |-> !input_limit_500_en)
    else $error("input limit not lifted");
  a_ovp_opens: assert property (vbus_ovp_trip[*4] |-> !input_switch_on)
    else $error("input switch closed in overvoltage");
  a_ntc_stops: assert property (ntc_hot[*4] |-> s_off)
    else $error("charging during battery temperature fault");
  a_neg_cut: assert property (low_side_neg_over[*4] |-> !low_side_en)
    else $error("low side on with negative current");
  a_stat_drain: assert property (stat_oe |-> !stat_out)
    else $error("status pin driven high");
  a_start_valid: assert property (
    $rose(precharge_en) || $rose(high_side_en) |-> valid_run >= VALID_CYC)
    else $error("charging before supply validated");
  a_blink_period: assert property (
    ntc_hot[*8] ##0 $changed(stat_oe) ##1 s_blink_run |-> $changed(stat_oe))
    else $error("status blink period wrong");
endmodule // bcc_charger_props
`default_nettype wire

//--- bcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bcc_host_model (
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       stat_out,
  input  wire logic       stat_oe,
  output var  logic       stat_pin,
  output var  logic [7:0] fall_count
);
  logic last_pin;
  // pull-up: a released pin reads high
  always_comb stat_pin = stat_oe ? stat_out : 1'b1;
  // falling edges are what an interrupt-driven host sees
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      fall_count <= 8'h00;
      last_pin <= 1'b1;
    end else begin
      last_pin <= stat_pin;
      if (last_pin && !stat_pin) fall_count <= fall_count + 8'h01;
    end
  end
endmodule // bcc_host_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock, rst_b, inhibit, limit_sel;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp;
  logic [16:0] cmp;
  logic        in_sw, prechg, hs_en, lim500, st_out, st_oe, st_pin;
  logic [7:0]  falls, f0;
  int          err_count, checks_done;
  bcc_charger #(.VALID_CYC(20), .DETECT_CYC(10), .BLINK_CYC(8),
    .RAMP_CYC(4)) dut_u (
    .clock(clock), .rst_b(rst_b), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .inhibit(inhibit), .input_limit_sel(limit_sel),
    .vbus_above_min(cmp[0]), .vbus_ovp_trip(cmp[1]),
    .vbus_ovp_clear(cmp[2]), .vbus_below_sleep(cmp[3]),
    .vbus_at_sp_floor(cmp[4]), .vbat_above_short(cmp[5]),
    .vbat_at_float(cmp[6]), .vbat_below_recharge(cmp[7]),
    .vbat_above_2v(cmp[8]), .vbat_over_4v8(cmp[9]),
    .ichg_at_term(cmp[10]), .ramp_at_limit(cmp[11]),
    .die_at_foldback(cmp[12]), .die_over_shutdown(cmp[13]),
    .ntc_hot(cmp[14]), .ntc_cold(cmp[15]), .low_side_neg_over(cmp[16]),
    .input_switch_on(in_sw), .input_load_en(), .reverse_block_en(),
    .precharge_en(prechg), .high_side_en(hs_en), .low_side_en(),
    .cv_en(), .foldback_en(), .detect_sink_en(), .nobat_regulate_en(),
    .input_limit_500_en(lim500), .charge_level(), .stat_out(st_out),
    .stat_oe(st_oe));
  bcc_host_model host_u (.clock(clock), .rst_b(rst_b), .stat_out(st_out),
    .stat_oe(st_oe), .stat_pin(st_pin), .fall_count(falls));
  ////////////////////////////////////////
  always #50 clock = ~clock;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clock);
      if (awready) aw_ok = 1;
      if (wready) w_ok = 1;
      if (aw_ok) awvalid <= 0;
      if (w_ok) wvalid <= 0;
    end while (!(aw_ok && w_ok));
    while (!bvalid) @(posedge clock);
    bready <= 0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rdr(input logic [3:0] a, input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clock); while (!arready);
    arvalid <= 0;
    while (!rvalid) @(posedge clock);
    rd = rdata;
    rready <= 0;
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic endt(input string s);
    $display("test %s done, mismatches %0d", s, err_count);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    summarize();
  end
  initial begin
    clock = 0;
    rst_b = 0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    inhibit = 1;
    limit_sel = 0;
    cmp = 17'h0_0100;
    err_count = 0;
    checks_done = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1;
    repeat (3) @(posedge clock);
    rdr(4'h0, 2'h0);
    chk(rd, 32'h0000_00ff);
    rdr(4'h4, 2'h0);
    chk(rd & 32'h0000_01ff, 32'h0000_0001);
    rdr(4'hc, 2'h2);
    wr(4'hc, 32'h0000_0001, 2'h2);
    wr(4'h0, 32'h0000_0003, 2'h0);
    endt("registers");
    cmp[0] <= 1;
    inhibit <= 0;
    repeat (12) @(posedge clock);
    chk(prechg, 0);
    chk(st_pin, 1);
    repeat (20) @(posedge clock);
    chk(prechg, 1);
    chk(st_pin, 0);
    cmp[5] <= 1;
    repeat (40) @(posedge clock);
    chk({hs_en, prechg}, 2'b10);
    rdr(4'h8, 2'h0);
    chk(rd, 32'h0000_0003);
    endt("charge");
    limit_sel <= 1;
    repeat (6) @(posedge clock);
    chk(lim500, 0);
    limit_sel <= 0;
    repeat (6) @(posedge clock);
    chk(lim500, 1);
    f0 = falls;
    cmp[14] <= 1;
    repeat (48) @(posedge clock);
    chk(hs_en, 0);
    chk(falls - f0 >= 8'h02, 1);
    rdr(4'h4, 2'h0);
    chk(rd & 32'h0000_8100, 32'h0000_8100);
    cmp[14] <= 0;
    repeat (40) @(posedge clock);
    cmp[1] <= 1;
    repeat (6) @(posedge clock);
    chk(in_sw, 0);
    rdr(4'h4, 2'h0);
    chk(rd & 32'h0000_0200, 32'h0000_0200);
    cmp[2:1] <= 2'b10;
    repeat (40) @(posedge clock);
    chk(hs_en, 1);
    cmp[3] <= 1;
    repeat (6) @(posedge clock);
    rdr(4'h4, 2'h0);
    chk(rd & 32'h0000_05ff, 32'h0000_0400);
    chk(hs_en, 0);
    cmp[3] <= 0;
    repeat (40) @(posedge clock);
    chk(hs_en, 1);
    endt("faults");
    f0 = falls;
    cmp[0] <= 0;
    repeat (6) @(posedge clock);
    chk({hs_en, st_pin}, 2'b01);
    repeat (8) @(posedge clock);
    chk(falls - f0, 1);
    cmp[0] <= 1;
    inhibit <= 1;
    repeat (6) @(posedge clock);
    rdr(4'h4, 2'h0);
    chk(rd & 32'h0000_01ff, 32'h0000_0001);
    endt("supply");
    summarize();
  end
endmodule // tb_top
bind bcc_charger bcc_charger_props #(.VALID_CYC(VALID_CYC)) props_u (
  .clock(clock), .rst_b(rst_b), .inhibit(inhibit),
  .input_limit_sel(input_limit_sel), .vbus_above_min(vbus_above_min),
  .vbus_ovp_trip(vbus_ovp_trip), .ntc_hot(ntc_hot),
  .low_side_neg_over(low_side_neg_over), .input_switch_on(input_switch_on),
  .precharge_en(precharge_en), .high_side_en(high_side_en),
  .low_side_en(low_side_en), .input_limit_500_en(input_limit_500_en),
  .stat_out(stat_out), .stat_oe(stat_oe));
`default_nettype wire
